//--- design/csp_pkg.sv
// Shared constants and types for the color sensor serial register port.
// Assumes a two-wire bus master on the far side and an external pull-up on the data line.
package csp_pkg;

  // ----------------------------------------------------------------
  // Bus constants
  // ----------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR   = 7'h74;
  localparam int         BYTE_BITS    = 8;
  localparam logic [2:0] LAST_BIT     = 3'h7;
  localparam int         REG_DEPTH    = 256;
  localparam logic       DIR_READ     = 1'b1;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLOCK_PERIOD_NS   = 5;
  localparam int RESET_MIN_NS      = 1000;
  localparam int RESET_MIN_CYCLES  = (RESET_MIN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RX   = 3'h1,
    ST_ACK  = 3'h3,
    ST_TX   = 3'h2,
    ST_MACK = 3'h6
  } csp_state_e;

  typedef enum logic [1:0] {
    KIND_ADDR  = 2'h0,
    KIND_INDEX = 2'h1,
    KIND_DATA  = 2'h2
  } csp_kind_e;

  typedef struct packed {
    logic [7:0] index;
    logic [7:0] data;
  } csp_write_s;

endpackage

//--- design/csp_serial_port.sv
// Two-wire slave port with a byte-wide register bank behind it.
// Assumes the link clock runs free and is much faster than the serial clock.
module csp_serial_port #(
  parameter int REG_DEPTH = csp_pkg::REG_DEPTH
) (
  // Core clock and resets
  input  wire logic         clock,
  input  wire logic         reset,
  input  wire logic         global_async_reset_n,
  // Link clock and serial pins
  input  wire logic         external_core_clock,
  input  wire logic         scl_in,
  input  wire logic         sda_in,
  output logic              sda_out,
  output logic              sda_oe_n,
  // Low-power control
  input  wire logic         sleep_request,
  output logic              analog_power_down,
  output logic              core_clock_gated,
  // Register write notice
  output logic              reg_write_valid,
  output csp_pkg::csp_write_s reg_write
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic index_in_range(input logic [7:0] idx);
    index_in_range = (32'(idx) < REG_DEPTH);
  endfunction

  // ----------------------------------------------------------------
  // Link domain: pin synchronisation and bus conditions
  // ----------------------------------------------------------------
  logic [1:0] pin_q;
  logic       scl_q;
  logic       sda_q;
  logic       scl_d_reg;
  logic       sda_d_reg;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_seen;
  logic       stop_seen;

  csp_sync #(
    .WIDTH       (2),
    .RESET_VALUE (2'h3)
  ) u_pin_sync (
    .clock         (external_core_clock),
    .async_reset_n (global_async_reset_n),
    .d             ({scl_in, sda_in}),
    .q             (pin_q)
  );

  assign scl_q = pin_q[1];
  assign sda_q = pin_q[0];

  always_ff @(posedge external_core_clock or negedge global_async_reset_n) begin
    if (!global_async_reset_n) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_q;
      sda_d_reg <= sda_q;
    end
  end

  // Data is sampled on the rising clock edge, where it must be stable.
  assign scl_rise   = scl_q & ~scl_d_reg;
  assign scl_fall   = ~scl_q & scl_d_reg;
  assign start_seen = scl_q & scl_d_reg & sda_d_reg & ~sda_q;
  assign stop_seen  = scl_q & scl_d_reg & ~sda_d_reg & sda_q;

  // ----------------------------------------------------------------
  // Link domain: byte engine
  // ----------------------------------------------------------------
  csp_pkg::csp_state_e state_reg;
  csp_pkg::csp_kind_e  kind_reg;
  logic [2:0]          bit_cnt_reg;
  logic                byte_full_reg;
  logic [7:0]          shift_reg;
  logic [7:0]          tx_shift_reg;
  logic                dir_read_reg;
  logic                master_ack_reg;
  logic                pull_low_reg;
  logic [7:0]          rd_hold_reg;
  logic                rx_byte_end;

  assign rx_byte_end = (state_reg == csp_pkg::ST_RX) && scl_fall && byte_full_reg;

  always_ff @(posedge external_core_clock or negedge global_async_reset_n) begin
    if (!global_async_reset_n) begin
      state_reg      <= csp_pkg::ST_IDLE;
      kind_reg       <= csp_pkg::KIND_ADDR;
      bit_cnt_reg    <= 3'h0;
      byte_full_reg  <= 1'b0;
      shift_reg      <= 8'h00;
      tx_shift_reg   <= 8'h00;
      dir_read_reg   <= 1'b0;
      master_ack_reg <= 1'b0;
      pull_low_reg   <= 1'b0;
    end else if (start_seen) begin
      // A repeated start behaves exactly like a first start.
      state_reg     <= csp_pkg::ST_RX;
      kind_reg      <= csp_pkg::KIND_ADDR;
      bit_cnt_reg   <= 3'h0;
      byte_full_reg <= 1'b0;
      dir_read_reg  <= 1'b0;
      pull_low_reg  <= 1'b0;
    end else if (stop_seen) begin
      state_reg    <= csp_pkg::ST_IDLE;
      pull_low_reg <= 1'b0;
    end else begin
      case (state_reg)
        csp_pkg::ST_RX: begin
          if (scl_rise) begin
            shift_reg   <= {shift_reg[6:0], sda_q};
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == csp_pkg::LAST_BIT) begin
              byte_full_reg <= 1'b1;
            end
          end else if (rx_byte_end) begin
            byte_full_reg <= 1'b0;
            case (kind_reg)
              csp_pkg::KIND_ADDR: begin
                if (shift_reg[7:1] == csp_pkg::SLAVE_ADDR) begin
                  dir_read_reg <= (shift_reg[0] == csp_pkg::DIR_READ);
                  pull_low_reg <= 1'b1;
                  state_reg    <= csp_pkg::ST_ACK;
                end else begin
                  state_reg <= csp_pkg::ST_IDLE;
                end
              end
              default: begin
                pull_low_reg <= 1'b1;
                state_reg    <= csp_pkg::ST_ACK;
              end
            endcase
          end
        end
        csp_pkg::ST_ACK: begin
          if (scl_fall) begin
            bit_cnt_reg <= 3'h0;
            if (dir_read_reg) begin
              state_reg    <= csp_pkg::ST_TX;
              tx_shift_reg <= rd_hold_reg;
              pull_low_reg <= ~rd_hold_reg[7];
            end else begin
              state_reg    <= csp_pkg::ST_RX;
              pull_low_reg <= 1'b0;
              kind_reg     <= (kind_reg == csp_pkg::KIND_ADDR) ? csp_pkg::KIND_INDEX
                                                               : csp_pkg::KIND_DATA;
            end
          end
        end
        csp_pkg::ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_reg == csp_pkg::LAST_BIT) begin
              // Let go of the line so the master can answer.
              pull_low_reg <= 1'b0;
              state_reg    <= csp_pkg::ST_MACK;
            end else begin
              bit_cnt_reg  <= bit_cnt_reg + 3'h1;
              tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
              pull_low_reg <= ~tx_shift_reg[6];
            end
          end
        end
        csp_pkg::ST_MACK: begin
          if (scl_rise) begin
            master_ack_reg <= ~sda_q;
          end else if (scl_fall) begin
            bit_cnt_reg <= 3'h0;
            if (master_ack_reg) begin
              // More bytes wanted: the same indexed byte is sent again.
              state_reg    <= csp_pkg::ST_TX;
              tx_shift_reg <= rd_hold_reg;
              pull_low_reg <= ~rd_hold_reg[7];
            end else begin
              state_reg <= csp_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          state_reg    <= csp_pkg::ST_IDLE;
          pull_low_reg <= 1'b0;
        end
      endcase
    end
  end

  // The pad only ever pulls low; a one is a released line.
  assign sda_out  = 1'b0;
  assign sda_oe_n = ~pull_low_reg;

  // ----------------------------------------------------------------
  // Link domain: requests toward the register bank
  // ----------------------------------------------------------------
  logic [7:0] index_reg;
  logic [7:0] wr_data_reg;
  logic       wr_toggle_reg;
  logic       rd_req_toggle_reg;
  logic       rd_ack_q;
  logic       rd_ack_d_reg;
  logic       rd_ack_toggle_reg;
  logic [7:0] rd_data_reg;

  // Index and data stay put for a whole byte time, far longer than the crossing.
  always_ff @(posedge external_core_clock or negedge global_async_reset_n) begin
    if (!global_async_reset_n) begin
      index_reg         <= 8'h00;
      wr_data_reg       <= 8'h00;
      wr_toggle_reg     <= 1'b0;
      rd_req_toggle_reg <= 1'b0;
    end else if (rx_byte_end && (kind_reg == csp_pkg::KIND_INDEX)) begin
      // Fetch early so the byte is ready before any read address arrives.
      index_reg         <= shift_reg;
      rd_req_toggle_reg <= ~rd_req_toggle_reg;
    end else if (rx_byte_end && (kind_reg == csp_pkg::KIND_DATA)) begin
      wr_data_reg   <= shift_reg;
      wr_toggle_reg <= ~wr_toggle_reg;
    end
  end

  csp_sync #(
    .WIDTH       (1),
    .RESET_VALUE (1'b0)
  ) u_ack_sync (
    .clock         (external_core_clock),
    .async_reset_n (global_async_reset_n),
    .d             (rd_ack_toggle_reg),
    .q             (rd_ack_q)
  );

  always_ff @(posedge external_core_clock or negedge global_async_reset_n) begin
    if (!global_async_reset_n) begin
      rd_ack_d_reg <= 1'b0;
      rd_hold_reg  <= 8'h00;
    end else begin
      rd_ack_d_reg <= rd_ack_q;
      if (rd_ack_q != rd_ack_d_reg) begin
        rd_hold_reg <= rd_data_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Core domain: crossing inputs
  // ----------------------------------------------------------------
  logic [2:0] core_q;
  logic       wr_toggle_q;
  logic       rd_req_q;
  logic       sleep_q;
  logic       wr_toggle_d_reg;
  logic       rd_req_d_reg;
  logic       wr_event;
  logic       rd_event;

  csp_sync #(
    .WIDTH       (3),
    .RESET_VALUE (3'h0)
  ) u_core_sync (
    .clock         (clock),
    .async_reset_n (global_async_reset_n),
    .d             ({wr_toggle_reg, rd_req_toggle_reg, sleep_request}),
    .q             (core_q)
  );

  assign wr_toggle_q = core_q[2];
  assign rd_req_q    = core_q[1];
  assign sleep_q     = core_q[0];
  assign wr_event    = wr_toggle_q != wr_toggle_d_reg;
  assign rd_event    = rd_req_q != rd_req_d_reg;

  always_ff @(posedge clock or negedge global_async_reset_n) begin
    if (!global_async_reset_n) begin
      wr_toggle_d_reg <= 1'b0;
      rd_req_d_reg    <= 1'b0;
    end else if (reset) begin
      wr_toggle_d_reg <= wr_toggle_q;
      rd_req_d_reg    <= rd_req_q;
    end else begin
      wr_toggle_d_reg <= wr_toggle_q;
      rd_req_d_reg    <= rd_req_q;
    end
  end

  // ----------------------------------------------------------------
  // Core domain: register bank
  // ----------------------------------------------------------------
  logic [7:0] bank_reg [REG_DEPTH];

  always_ff @(posedge clock or negedge global_async_reset_n) begin
    if (!global_async_reset_n) begin
      for (int i = 0; i < REG_DEPTH; i++) begin
        bank_reg[i] <= 8'h00;
      end
    end else if (reset) begin
      for (int i = 0; i < REG_DEPTH; i++) begin
        bank_reg[i] <= 8'h00;
      end
    end else if (wr_event && index_in_range(index_reg)) begin
      bank_reg[index_reg] <= wr_data_reg;
    end
  end

  // Indices beyond the bank read as zero and swallow writes.
  always_ff @(posedge clock or negedge global_async_reset_n) begin
    if (!global_async_reset_n) begin
      rd_data_reg       <= 8'h00;
      rd_ack_toggle_reg <= 1'b0;
    end else if (rd_event) begin
      rd_data_reg       <= index_in_range(index_reg) ? bank_reg[index_reg] : 8'h00;
      rd_ack_toggle_reg <= ~rd_ack_toggle_reg;
    end
  end

  always_ff @(posedge clock or negedge global_async_reset_n) begin
    if (!global_async_reset_n) begin
      reg_write_valid <= 1'b0;
      reg_write       <= '0;
    end else if (reset) begin
      reg_write_valid <= 1'b0;
      reg_write       <= '0;
    end else begin
      reg_write_valid <= wr_event && index_in_range(index_reg);
      if (wr_event) begin
        reg_write.index <= index_reg;
        reg_write.data  <= wr_data_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Core domain: sleep control
  // ----------------------------------------------------------------
  // The serial engine keeps running on the link clock so the bus stays responsive.
  always_ff @(posedge clock or negedge global_async_reset_n) begin
    if (!global_async_reset_n) begin
      analog_power_down <= 1'b0;
      core_clock_gated  <= 1'b0;
    end else if (reset) begin
      analog_power_down <= 1'b0;
      core_clock_gated  <= 1'b0;
    end else begin
      analog_power_down <= sleep_q;
      core_clock_gated  <= sleep_q;
    end
  end

endmodule // csp_serial_port

//--- design/csp_sync.sv
// Two-stage synchroniser for a group of single-bit levels or toggles.
// Assumes each bit changes no faster than the receiving clock can follow.
module csp_sync #(
  parameter int               WIDTH       = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Receiving clock and reset
  input  wire logic             clock,
  input  wire logic             async_reset_n,
  // Levels in and out
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;

  // The first stage feeds only the second.
  always_ff @(posedge clock or negedge async_reset_n) begin
    if (!async_reset_n) begin
      meta_reg <= RESET_VALUE;
      q        <= RESET_VALUE;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule // csp_sync

//--- tb/csp_master_model.sv
// Two-wire bus master model, driven by task calls from the bench.
// Assumes an open-drain data wire with a pull-up, resolved by the bench.
module csp_master_model #(
  parameter int HALF = 100
) (
  // Core clock and resolved data wire
  input  wire logic clock,
  input  wire logic sda_wire,
  // Driven pins; a one on sda_drv means released
  output logic      scl,
  output logic      sda_drv
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask

  // The long low phase first leaves the slave over a microsecond before a restart.
  task automatic start_cond();
    sda_drv <= 1'b1;
    wt(HALF * 2);
    scl <= 1'b1;
    wt(HALF);
    sda_drv <= 1'b0;
    wt(HALF);
    scl <= 1'b0;
    wt(HALF / 8);
  endtask

  task automatic stop_cond();
    sda_drv <= 1'b0;
    wt(HALF);
    scl <= 1'b1;
    wt(HALF);
    sda_drv <= 1'b1;
    wt(HALF);
  endtask

  task automatic bit_io(input logic b, output logic r);
    sda_drv <= b;
    wt(HALF);
    scl <= 1'b1;
    wt(HALF);
    r = sda_wire;
    scl <= 1'b0;
    wt(HALF / 8);
  endtask

  task automatic send_byte(input logic [7:0] v, output logic acked);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(v[i], r);
    bit_io(1'b1, r);
    acked = ~r;
  endtask

  task automatic recv_byte(input logic give_ack, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
    bit_io(~give_ack, r);
  endtask
endmodule // csp_master_model

//--- tb/csp_serial_port_props.sv
// Port-level checker for the serial register port.
// Assumes it sees only the top module's ports, through the bind below.
module csp_serial_port_props #(
  parameter int REG_DEPTH = csp_pkg::REG_DEPTH
) (
  // Core domain
  input wire logic                clock,
  input wire logic                reset,
  input wire logic                global_async_reset_n,
  input wire logic                sleep_request,
  input wire logic                analog_power_down,
  input wire logic                core_clock_gated,
  input wire logic                reg_write_valid,
  input wire csp_pkg::csp_write_s reg_write,
  // Link domain
  input wire logic                external_core_clock,
  input wire logic                scl_in,
  input wire logic                sda_in,
  input wire logic                sda_out,
  input wire logic                sda_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // Sequences and assertions
  // ----------------------------------------------------------------
  sequence s_sleep_on;
    !sleep_request ##1 sleep_request;
  endsequence

  sequence s_start;
    scl_in && sda_in ##1 scl_in && !sda_in;
  endsequence

  chk_data_low: assert property (@(posedge clock) disable iff (reset) sda_out == 1'b0)
    else $error("data line driven high");
  chk_sleep_enter: assert property (@(posedge clock) disable iff (reset || !global_async_reset_n)
    s_sleep_on |-> ##3 analog_power_down && core_clock_gated) else $error("sleep entry late");
  chk_sleep_leave: assert property (@(posedge clock) disable iff (reset || !global_async_reset_n)
    $fell(sleep_request) |-> ##3 !analog_power_down) else $error("sleep exit late");
  chk_sleep_pair: assert property (@(posedge clock) disable iff (reset)
    analog_power_down == core_clock_gated) else $error("sleep outputs disagree");
  chk_async_clear: assert property (@(posedge clock) disable iff (reset)
    !global_async_reset_n |-> sda_oe_n && !reg_write_valid && !analog_power_down
    && reg_write == 16'h0000) else $error("hard reset not clearing");
  chk_notice_pulse: assert property (@(posedge clock) disable iff (reset || !global_async_reset_n)
    reg_write_valid |=> !reg_write_valid) else $error("write notice longer than one cycle");
  chk_notice_change: assert property (@(posedge clock) disable iff (reset || !global_async_reset_n)
    $changed(reg_write) && !$past(reset) |-> reg_write_valid) else $error("silent write change");
  chk_oe_scl_low: assert property (@(posedge external_core_clock)
    disable iff (!global_async_reset_n)
    $changed(sda_oe_n) |-> !scl_in && !$past(scl_in)) else $error("data changed with clock high");
  chk_start_quiet: assert property (@(posedge external_core_clock)
    disable iff (!global_async_reset_n)
    s_start |-> sda_oe_n[*8]) else $error("data line driven after start");
endmodule // csp_serial_port_props

bind csp_serial_port csp_serial_port_props #(.REG_DEPTH(REG_DEPTH)) i_props (
  .clock(clock), .reset(reset), .global_async_reset_n(global_async_reset_n),
  .sleep_request(sleep_request), .analog_power_down(analog_power_down),
  .core_clock_gated(core_clock_gated), .reg_write_valid(reg_write_valid),
  .reg_write(reg_write), .external_core_clock(external_core_clock), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n));

//--- tb/tb.sv
// Self-checking bench for the serial register port.
// Assumes the master model and the bound checker are compiled alongside.
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // Signals, clocks and instances
  // ----------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR = 7'h74;
  logic                clock = 1'b0;
  logic                reset = 1'b1;
  logic                global_async_reset_n = 1'b1;
  logic                external_core_clock = 1'b0;
  logic                sleep_request = 1'b0;
  logic                scl;
  logic                sda_drv;
  logic                sda_out;
  logic                sda_oe_n;
  logic                analog_power_down;
  logic                core_clock_gated;
  logic                reg_write_valid;
  csp_pkg::csp_write_s reg_write;
  logic [15:0]         last_wr = 16'h0000;
  int                  n_wr = 0;
  int                  n_mismatch = 0;
  int                  n_compared = 0;
  wire logic           sda_wire = sda_drv & (sda_oe_n | sda_out);

  always #2.5 clock = ~clock;
  initial begin
    #11;
    forever #32 external_core_clock = ~external_core_clock;
  end
  always @(posedge clock) begin
    if (reg_write_valid === 1'b1) begin
      n_wr <= n_wr + 1;
      last_wr <= reg_write;
    end
  end

  csp_serial_port i_dut (.clock(clock), .reset(reset),
    .global_async_reset_n(global_async_reset_n), .external_core_clock(external_core_clock),
    .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .sleep_request(sleep_request), .analog_power_down(analog_power_down),
    .core_clock_gated(core_clock_gated), .reg_write_valid(reg_write_valid),
    .reg_write(reg_write));
  csp_master_model #(.HALF(100)) i_master (.clock(clock), .sda_wire(sda_wire), .scl(scl),
    .sda_drv(sda_drv));

  // ----------------------------------------------------------------
  // Checks and scenarios
  // ----------------------------------------------------------------
  task automatic chk_bit(input string what, input logic exp, input logic seen);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] seen);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic addr_index(input logic [7:0] idx);
    logic a;
    i_master.start_cond();
    i_master.send_byte({DEV_ADDR, 1'b0}, a);
    chk_bit("write address ack", 1'b1, a);
    i_master.send_byte(idx, a);
    chk_bit("index ack", 1'b1, a);
  endtask

  task automatic t_write(input logic [7:0] idx, input logic [7:0] dat);
    int   n0;
    logic a;
    n0 = n_wr;
    addr_index(idx);
    i_master.send_byte(dat, a);
    chk_bit("data ack", 1'b1, a);
    i_master.stop_cond();
    chk_val("write count", 16'(n0 + 1), 16'(n_wr));
    chk_val("write notice", {idx, dat}, last_wr);
  endtask

  task automatic t_read(input logic [7:0] idx, input logic [7:0] exp, input logic twice);
    int         n0;
    logic       a;
    logic [7:0] v;
    n0 = n_wr;
    addr_index(idx);
    i_master.start_cond();
    i_master.send_byte({DEV_ADDR, 1'b1}, a);
    chk_bit("read address ack", 1'b1, a);
    // An acknowledged byte makes the port send the same indexed byte again.
    if (twice) begin
      i_master.recv_byte(1'b1, v);
      chk_val("first read data", {8'h00, exp}, {8'h00, v});
    end
    i_master.recv_byte(1'b0, v);
    i_master.stop_cond();
    chk_val("read data", {8'h00, exp}, {8'h00, v});
    chk_val("writes during read", 16'(n0), 16'(n_wr));
  endtask

  task automatic t_foreign();
    logic [6:0] others [4] = '{7'h75, 7'h34, 7'h76, 7'h70};
    logic       a;
    int         n0;
    n0 = n_wr;
    foreach (others[i]) begin
      i_master.start_cond();
      i_master.send_byte({others[i], 1'b0}, a);
      chk_bit("foreign address ack", 1'b0, a);
      i_master.send_byte(8'h00, a);
      chk_bit("foreign index ack", 1'b0, a);
      i_master.stop_cond();
    end
    chk_val("foreign writes", 16'(n0), 16'(n_wr));
  endtask

  task automatic t_sleep();
    int k;
    k = 0;
    sleep_request <= 1'b1;
    while (analog_power_down !== 1'b1 && k < 9) begin
      @(posedge clock);
      #1 k++;
    end
    chk_val("sleep latency", 16'd3, 16'(k));
    chk_bit("core clock gated", 1'b1, core_clock_gated);
    if (k > 8) tally_and_finish();
    @(posedge clock);
    sleep_request <= 1'b0;
    repeat (4) @(posedge clock);
    #1 chk_bit("awake again", 1'b0, analog_power_down);
    @(posedge clock);
  endtask

  // The last notice is non-zero here, so clearing it without a clock edge shows.
  task automatic t_hard_reset();
    global_async_reset_n <= 1'b0;
    #1 chk_val("notice cleared at once", 16'h0000, reg_write);
    chk_bit("data line released", 1'b1, sda_oe_n);
    repeat (200) @(posedge clock);
    global_async_reset_n <= 1'b1;
    repeat (20) @(posedge clock);
    t_read(8'hfe, 8'h00, 1'b0);
  endtask

  initial begin
    // A real falling edge at time zero puts both domains into reset at once.
    global_async_reset_n <= 1'b0;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    repeat (198) @(posedge clock);
    global_async_reset_n <= 1'b1;
    repeat (20) @(posedge clock);
    t_write(8'h05, 8'ha5);
    t_write(8'hfe, 8'h3c);
    t_read(8'h05, 8'ha5, 1'b0);
    t_read(8'hfe, 8'h3c, 1'b1);
    t_foreign();
    t_sleep();
    t_hard_reset();
    tally_and_finish();
  end
endmodule // tb
